// ---- hdl/pmwc_top.sv ----
// Power mode and wake-up control block on the special function register bus
`timescale 1ns/1ps
module pmwc_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_q,
   input wire logic irq_pending,
   input wire logic comparator_zero_wake,
   input wire logic port_match_wake,
   input wire logic rtc_alarm_wake,
   input wire logic rtc_osc_fail_wake,
   input wire logic reset_pin_glitch_flag,
   output logic idle_q,
   output logic stop_q,
   output logic suspend_q,
   output logic sleep_q,
   output logic lp_osc_keep_on_q,
   output logic wakeup_pulse_q
);
   // ----------------------------------------
   // Event synchronisers
   // ----------------------------------------
   logic [4:0] ev_raw;
   logic [4:0] s1_q, s2_q, s3_q, lvl_q;
   logic [4:0] s1_d, s2_d, s3_d, lvl_d;
   logic [4:0] ev;

   assign ev_raw = {reset_pin_glitch_flag, rtc_osc_fail_wake, rtc_alarm_wake,
                    port_match_wake, comparator_zero_wake};

   genvar gi;
   generate
      for (gi = 0; gi < pmwc_pkg::NUM_EVENTS; gi++) begin : g_sync
         // Level only moves once the last two stages agree
         always_comb begin
            s1_d[gi] = ev_raw[gi];
            s2_d[gi] = s1_q[gi];
            s3_d[gi] = s2_q[gi];
            lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
            ev[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !lvl_q[gi];
         end
         always_ff @(posedge clk) begin
            if (!resetn) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               lvl_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= s1_d[gi];
               s2_q[gi] <= s2_d[gi];
               s3_q[gi] <= s3_d[gi];
               lvl_q[gi] <= lvl_d[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Registers and mode control
   // ----------------------------------------
   pmwc_pkg::pmwc_mode_t mode_q, mode_d;
   logic [3:0] enable_q, enable_d;
   logic [4:0] flags_q, flags_d;
   logic [5:0] gpf_q, gpf_d;
   logic [7:0] rdata_d;
   logic wr_wk, wr_pc, clr, blocked, asleep, wake_hit, wake_d;

   always_comb begin
      wr_wk = sfr_wr && (sfr_addr == pmwc_pkg::ADDR_WAKEUP_CONFIGURATION);
      wr_pc = sfr_wr && (sfr_addr == pmwc_pkg::ADDR_POWER_CONTROL);
      clr = wr_wk && sfr_wdata[pmwc_pkg::BIT_CLEAR];
      asleep = (mode_q == pmwc_pkg::PMWC_SLEEP) || (mode_q == pmwc_pkg::PMWC_SUSPEND);
      // Only enabled sources wake; a reset pin glitch always does
      wake_hit = asleep && ((|(ev[pmwc_pkg::NUM_SOURCES-1:0] & enable_q)) ||
                 ev[pmwc_pkg::BIT_RESET_GLITCH]);
      mode_d = mode_q;
      enable_d = enable_q;
      gpf_d = gpf_q;
      wake_d = 1'b0;
      // Clear strobe wins over old flags, new events win over the clear
      flags_d = clr ? pmwc_pkg::FLAGS_RESET : flags_q;
      flags_d[4:1] = flags_d[4:1] | ev[4:1];
      if (wake_hit && ev[pmwc_pkg::SRC_COMPARATOR] && enable_q[pmwc_pkg::SRC_COMPARATOR]) begin
         flags_d[pmwc_pkg::SRC_COMPARATOR] = 1'b1;
      end
      // A clear in the same write lets the entry through
      blocked = (|flags_q) && !clr;
      if (wr_wk) begin
         enable_d = sfr_wdata[pmwc_pkg::NUM_SOURCES-1:0];
      end
      if (wr_pc) begin
         gpf_d = sfr_wdata[7:pmwc_pkg::GPF_LSB];
      end
      case (mode_q)
         pmwc_pkg::PMWC_RUN: begin
            if (wr_wk && sfr_wdata[pmwc_pkg::BIT_SLEEP] && !blocked) begin
               mode_d = pmwc_pkg::PMWC_SLEEP;
            end else if (wr_wk && sfr_wdata[pmwc_pkg::BIT_SUSPEND] && !blocked) begin
               mode_d = pmwc_pkg::PMWC_SUSPEND;
            end else if (wr_pc && sfr_wdata[pmwc_pkg::BIT_STOP]) begin
               mode_d = pmwc_pkg::PMWC_STOP;
            end else if (wr_pc && sfr_wdata[pmwc_pkg::BIT_IDLE]) begin
               mode_d = pmwc_pkg::PMWC_IDLE;
            end
         end
         pmwc_pkg::PMWC_IDLE: begin
            if (irq_pending) begin
               mode_d = pmwc_pkg::PMWC_RUN;
            end
         end
         pmwc_pkg::PMWC_STOP: begin
            mode_d = pmwc_pkg::PMWC_STOP;
         end
         pmwc_pkg::PMWC_SUSPEND, pmwc_pkg::PMWC_SLEEP: begin
            if (wake_hit) begin
               mode_d = pmwc_pkg::PMWC_RUN;
               wake_d = 1'b1;
            end
         end
         default: begin
            mode_d = pmwc_pkg::PMWC_RUN;
         end
      endcase
      // Strobe bits read zero; flags replace enables on read
      rdata_d = sfr_rdata_q;
      if (sfr_rd) begin
         if (sfr_addr == pmwc_pkg::ADDR_WAKEUP_CONFIGURATION) begin
            rdata_d = {3'h0, flags_q};
         end else if (sfr_addr == pmwc_pkg::ADDR_POWER_CONTROL) begin
            rdata_d = {gpf_q, pmwc_pkg::UNUSED_READ};
         end else begin
            rdata_d = pmwc_pkg::RDATA_RESET;
         end
      end
   end

   // Stop leaves only through this reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_q <= pmwc_pkg::PMWC_RUN;
         enable_q <= pmwc_pkg::ENABLE_RESET;
         flags_q <= pmwc_pkg::FLAGS_RESET;
         gpf_q <= pmwc_pkg::GPF_RESET;
         sfr_rdata_q <= pmwc_pkg::RDATA_RESET;
         idle_q <= 1'b0;
         stop_q <= 1'b0;
         suspend_q <= 1'b0;
         sleep_q <= 1'b0;
         lp_osc_keep_on_q <= 1'b0;
         wakeup_pulse_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         enable_q <= enable_d;
         flags_q <= flags_d;
         gpf_q <= gpf_d;
         sfr_rdata_q <= rdata_d;
         idle_q <= (mode_d == pmwc_pkg::PMWC_IDLE);
         stop_q <= (mode_d == pmwc_pkg::PMWC_STOP);
         suspend_q <= (mode_d == pmwc_pkg::PMWC_SUSPEND);
         sleep_q <= (mode_d == pmwc_pkg::PMWC_SLEEP);
         lp_osc_keep_on_q <= |flags_d;
         wakeup_pulse_q <= wake_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_sleep_request;
      mode_q == pmwc_pkg::PMWC_RUN && wr_wk && sfr_wdata[pmwc_pkg::BIT_SLEEP];
   endsequence

   sequence s_stop_request;
      mode_q == pmwc_pkg::PMWC_RUN && wr_pc && sfr_wdata[pmwc_pkg::BIT_STOP] &&
         !(wr_wk && (sfr_wdata[pmwc_pkg::BIT_SLEEP] || sfr_wdata[pmwc_pkg::BIT_SUSPEND]));
   endsequence

   a_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
      s_sleep_request ##0 (flags_q == 5'h00 || clr) |=> sleep_q && !idle_q)
      else $error("sleep request with no flags did not enter sleep");

   a_flags_block: assert property (@(posedge clk) disable iff (!resetn)
      (|flags_q) && !clr && mode_q == pmwc_pkg::PMWC_RUN |=> !sleep_q && !suspend_q)
      else $error("sleep or suspend entered while a wake-up flag was set");

   a_osc_kept: assert property (@(posedge clk) disable iff (!resetn)
      (|flags_q) && !wr_wk |=> lp_osc_keep_on_q)
      else $error("low power oscillator released while flags set");

   a_clear_flags: assert property (@(posedge clk) disable iff (!resetn)
      clr && ev == 5'h00 |=> flags_q == 5'h00 && !lp_osc_keep_on_q)
      else $error("clear strobe left a wake-up flag set");

   a_glitch_flag: assert property (@(posedge clk) disable iff (!resetn)
      $rose(lvl_q[pmwc_pkg::BIT_RESET_GLITCH]) |-> flags_q[pmwc_pkg::BIT_RESET_GLITCH])
      else $error("reset pin glitch not flagged");

   a_stop_forever: assert property (@(posedge clk) disable iff (!resetn)
      s_stop_request |=> stop_q [*8])
      else $error("stop mode left without reset");

   a_idle_exit: assert property (@(posedge clk) disable iff (!resetn)
      idle_q && irq_pending |=> !idle_q)
      else $error("idle mode not ended by pending interrupt");

   a_no_stray_wake: assert property (@(posedge clk) disable iff (!resetn)
      sleep_q && (ev[pmwc_pkg::NUM_SOURCES-1:0] & enable_q) == 4'h0 &&
         !ev[pmwc_pkg::BIT_RESET_GLITCH] |=> sleep_q)
      else $error("sleep left without an enabled wake-up event");

   a_gpf_readback: assert property (@(posedge clk) disable iff (!resetn)
      wr_pc ##1 !sfr_wr ##1 (sfr_rd && sfr_addr == pmwc_pkg::ADDR_POWER_CONTROL && !sfr_wr)
      |=> sfr_rdata_q == ($past(sfr_wdata, 3) & 8'hFC))
      else $error("general purpose flags did not read back");

   a_comp_cause: assert property (@(posedge clk) disable iff (!resetn)
      $rose(flags_q[pmwc_pkg::SRC_COMPARATOR]) |-> wakeup_pulse_q)
      else $error("comparator flag set without causing a wake-up");
endmodule // pmwc_top

// ---- hdl/pmwc_pkg.sv ----
// Constants and types shared by the power mode and wake-up control block
//
// Notes on behaviour
// - Writing one to wake-up configuration bit 7 enters Sleep mode; write-only.
// - Writing one to wake-up configuration bit 6 enters Suspend mode; write-only.
// - Writing one to bit 5 clears all latched wake-up flags together.
// - Bit 4 reads one after a glitch on the reset pin.
// - Bit 3 enables oscillator-fail wake-up; reads one if oscillator failed.
// - Bit 2 enables alarm wake-up; reads one if an alarm occurred.
// - Bit 1 enables port match wake-up; reads one if a match occurred.
// - Bit 0 enables comparator rising-edge wake-up; reads one if it caused last wake.
// - Any set flag blocks Sleep and Suspend and keeps the low power oscillator on.
// - Power control bits 7 to 2 are general purpose flags, reset zero.
// - Writing one to power control bit 1 enters Stop mode; write-only.
// - Writing one to power control bit 0 enters Idle mode; write-only.
// - Idle ends on an enabled interrupt, clearing idle select; reset also ends it.
// - Stop ends only through reset, after which execution restarts at zero.
package pmwc_pkg;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_WAKEUP_CONFIGURATION = 8'hB5;

   // ----------------------------------------
   // Wake-up configuration fields
   // ----------------------------------------
   localparam int BIT_SLEEP = 7;
   localparam int BIT_SUSPEND = 6;
   localparam int BIT_CLEAR = 5;
   localparam int BIT_RESET_GLITCH = 4;
   localparam int NUM_SOURCES = 4;
   localparam int NUM_EVENTS = 5;
   localparam int SRC_COMPARATOR = 0;

   // ----------------------------------------
   // Power control fields
   // ----------------------------------------
   localparam int BIT_STOP = 1;
   localparam int BIT_IDLE = 0;
   localparam int GPF_LSB = 2;
   localparam int GPF_W = 6;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [5:0] GPF_RESET = 6'h00;
   localparam logic [3:0] ENABLE_RESET = 4'h0;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam logic [1:0] UNUSED_READ = 2'h0;

   typedef enum logic [2:0] {
      PMWC_RUN = 3'b000,
      PMWC_IDLE = 3'b001,
      PMWC_STOP = 3'b010,
      PMWC_SUSPEND = 3'b011,
      PMWC_SLEEP = 3'b100
   } pmwc_mode_t;
endpackage

// ---- tb/pmwc_wake_src.sv ----
// Model of the wake-up event sources and interrupt logic around the block
`timescale 1ns/1ps
module pmwc_wake_src (
   input wire logic clk,
   input wire logic [4:0] fire_req,
   input wire logic irq_req,
   output logic [4:0] ev,
   output logic irq
);
   logic [4:0] ev_q = 5'h00;
   logic irq_q = 1'b0;
   logic [3:0] hold_q [5];

   assign ev = ev_q;
   assign irq = irq_q;

   // One request raises a level for 8 cycles, long enough for a 3-stage synchroniser
   always @(posedge clk) begin
      irq_q <= irq_req;
      for (int i = 0; i < 5; i++) begin
         if (fire_req[i]) begin
            ev_q[i] <= 1'b1;
            hold_q[i] <= 4'h7;
         end else if (ev_q[i]) begin
            hold_q[i] <= hold_q[i] - 4'h1;
            ev_q[i] <= (hold_q[i] != 4'h0);
         end
      end
   end
endmodule // pmwc_wake_src

// ---- tb/power_mode_wakeup_control_tb.sv ----
// Self-checking testbench for the power mode and wake-up control block
`timescale 1ns/1ps
module power_mode_wakeup_control_tb;
   logic clk, resetn, sfr_wr, sfr_rd;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
   logic idle_q, stop_q, suspend_q, sleep_q, lp_osc_keep_on_q, wakeup_pulse_q;
   logic [4:0] ev;
   logic irq;
   logic [4:0] fire_req;
   logic irq_req;
   int n_mismatch = 0;
   int checks_done = 0;
   localparam logic [7:0] PC = pmwc_pkg::ADDR_POWER_CONTROL;
   localparam logic [7:0] WC = pmwc_pkg::ADDR_WAKEUP_CONFIGURATION;

   pmwc_top u_dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .irq_pending(irq),
      .comparator_zero_wake(ev[0]), .port_match_wake(ev[1]), .rtc_alarm_wake(ev[2]),
      .rtc_osc_fail_wake(ev[3]), .reset_pin_glitch_flag(ev[4]), .idle_q(idle_q),
      .stop_q(stop_q), .suspend_q(suspend_q), .sleep_q(sleep_q),
      .lp_osc_keep_on_q(lp_osc_keep_on_q), .wakeup_pulse_q(wakeup_pulse_q));
   pmwc_wake_src u_src (.clk(clk), .fire_req(fire_req), .irq_req(irq_req), .ev(ev),
      .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(posedge clk);
      #1;
      chk(n, e, sfr_rdata_q);
   endtask

   // Bounded wait for the wake pulse, then the mode must be back to Run
   task automatic wake();
      int i;
      for (i = 0; i < 20 && wakeup_pulse_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("wake_pulse", 8'h01, {7'h00, wakeup_pulse_q});
      chk("asleep", 8'h00, {6'h00, sleep_q, suspend_q});
      chk("osc_keep", 8'h01, {7'h00, lp_osc_keep_on_q});
   endtask

   // One-cycle request; returns once the source level has fallen again
   task automatic fire(input int idx);
      @(posedge clk);
      fire_req[idx] <= 1'b1;
      @(posedge clk);
      fire_req[idx] <= 1'b0;
      repeat (9) @(posedge clk);
      #1;
   endtask

   // Interrupt passes one model stage, so the block sees it two edges later
   task automatic set_irq(input logic v);
      @(posedge clk);
      irq_req <= v;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic pulse_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #20000;
      n_mismatch++;
      print_verdict();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      fire_req = 5'h00;
      irq_req = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(PC, 8'h00, "power_control_reset");
      rd(WC, 8'h00, "wcfg_reset");
      rd(8'h12, 8'h00, "unmapped");
      wr(PC, 8'hA4);
      rd(PC, 8'hA4, "gpf");
      wr(PC, 8'hA5);
      chk("idle_on", 8'h01, {7'h00, idle_q});
      rd(PC, 8'hA4, "idle_wo");
      set_irq(1'b1);
      chk("idle_off", 8'h00, {7'h00, idle_q});
      set_irq(1'b0);
      $display("test registers_idle done");
      wr(WC, 8'h82);
      chk("sleep_on", 8'h01, {7'h00, sleep_q});
      fork fire(1); wake(); join
      rd(WC, 8'h02, "port_flag");
      wr(WC, 8'h40);
      chk("susp_refused", 8'h00, {7'h00, suspend_q});
      wr(WC, 8'h20);
      rd(WC, 8'h00, "cleared");
      chk("osc_free", 8'h00, {7'h00, lp_osc_keep_on_q});
      $display("test sleep_port done");
      wr(WC, 8'h41);
      chk("susp_on", 8'h01, {7'h00, suspend_q});
      fork fire(0); wake(); join
      rd(WC, 8'h01, "cmp_flag");
      wr(WC, 8'h64);
      fire(3);
      chk("no_wake", 8'h01, {7'h00, suspend_q});
      fork fire(2); wake(); join
      rd(WC, 8'h0C, "rtc_flags");
      wr(WC, 8'hE0);
      chk("sleep_prio", 8'h02, {6'h00, sleep_q, suspend_q});
      fork fire(4); wake(); join
      rd(WC, 8'h10, "glitch_flag");
      wr(WC, 8'h20);
      $display("test wake_sources done");
      wr(PC, 8'hFE);
      chk("stop_on", 8'h01, {7'h00, stop_q});
      set_irq(1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk("stop_held", 8'h01, {7'h00, stop_q});
      set_irq(1'b0);
      pulse_reset();
      chk("stop_off", 8'h00, {7'h00, stop_q});
      rd(PC, 8'h00, "power_control_rst2");
      wr(PC, 8'h01);
      chk("idle_on2", 8'h01, {7'h00, idle_q});
      pulse_reset();
      chk("idle_rst", 8'h00, {7'h00, idle_q});
      $display("test stop_reset done");
      print_verdict();
   end
endmodule // power_mode_wakeup_control_tb
